// ==== spi_nvm_pkg.sv ====
package spi_nvm_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR    = 8'h04;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

    // ------------------------------------------------------------
    // Array geometry (2048-byte variant; 10 for the 1024-byte one)
    // ------------------------------------------------------------
    localparam int          ARRAY_AW    = 11;
    localparam int          ARRAY_DEPTH = 2048;
    localparam int          PAGE_AW     = 5;
    localparam int          PAGE_BYTES  = 32;

    // ------------------------------------------------------------
    // Status register layout and values after reset
    // ------------------------------------------------------------
    localparam int          SR_PROT_EN_BIT = 7;
    localparam int          SR_GUARD_HI    = 3;
    localparam int          SR_GUARD_LO    = 2;
    localparam int          SR_WEL_BIT     = 1;
    localparam int          SR_BUSY_BIT    = 0;
    localparam logic [2:0]  SR_FIXED       = 3'h2;
    localparam logic [1:0]  GUARD_RST      = 2'h0;
    localparam logic        PROT_EN_RST    = 1'b0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int WRITE_TIME_MS    = 5;
    localparam int WRITE_TIME_LV_MS = 10;
    localparam int WRITE_CYCLES     = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES_LV  = WRITE_TIME_LV_MS * 1000000 / CLK_PERIOD_NS;
    localparam int COMMIT_AW        = 6;

    typedef enum logic [2:0] {
        ST_OPCODE  = 3'h0,
        ST_ADDR_HI = 3'h1,
        ST_ADDR_LO = 3'h2,
        ST_RD_DATA = 3'h3,
        ST_WR_DATA = 3'h4,
        ST_SR_DATA = 3'h5,
        ST_SR_OUT  = 3'h6,
        ST_IGNORE  = 3'h7
    } phase_e;

endpackage : spi_nvm_pkg

// ==== spi_nvm_access.sv ====
// Operation
// - First byte after select falls is the opcode choosing one of six commands.
// - Opcode, address and data bits are sampled on serial clock rising edges.
// - Read data changes on serial clock falling edges.
// - Opcode 06h sets the write enable latch.
// - Opcode 04h clears the write enable latch.
// - Opcode 05h shifts the status byte out.
// - Opcode 01h takes one data byte into the status register.
// - Opcode 03h takes an address, then returns array bytes.
// - Opcode 02h takes an address and data bytes to program.
// - Large variant uses address bits 10..0, upper bits ignored.
// - Select high puts output in high impedance; standby unless writing.
// - Internal write starts only on select rising after valid write.
// - Internal write lasts at most 5 ms (10 ms low-voltage grade).
// - Status bits: protect enable, fixed 010, two guard bits, latch, busy.
// - Guard code 00 protects nothing; 01 protects top quarter.
// - Guard code 10 protects the upper half against writes.
// - Guard code 11 protects the whole array; reads still allowed.
// - Read pointer advances per byte and wraps to zero at top.
// - Page write wraps inside its 32-byte page, overwriting bytes.
// - While writing internally only the status read is accepted.
// - Latch sets on select rising after opcode; cleared at power-up and write end.
module spi_nvm_access
    import spi_nvm_pkg::*;
#(
    parameter int unsigned P_WRITE_CYCLES = WRITE_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    input  wire logic i_cs_n,
    input  wire logic i_sck,
    input  wire logic i_si,
    output logic      o_so,
    output logic      o_so_oe,
    output logic      o_busy
);

    // ------------------------------------------------------------
    // Pin synchronisers and serial clock edge detection
    // ------------------------------------------------------------
    logic [1:0] cs_sync_q;
    logic [1:0] si_sync_q;
    logic [2:0] sck_sync_q;
    logic       cs_prev_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_sync_q  <= 2'h3;
            si_sync_q  <= 2'h0;
            sck_sync_q <= 3'h0;
            cs_prev_q  <= 1'b1;
        end else begin
            cs_sync_q  <= {cs_sync_q[0], i_cs_n};
            si_sync_q  <= {si_sync_q[0], i_si};
            sck_sync_q <= {sck_sync_q[1:0], i_sck};
            cs_prev_q  <= cs_sync_q[1];
        end
    end

    logic cs_hi;
    logic si_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    assign cs_hi    = cs_sync_q[1];
    assign si_s     = si_sync_q[1];
    assign sck_rise = !cs_hi && sck_sync_q[1] && !sck_sync_q[2];
    assign sck_fall = !cs_hi && !sck_sync_q[1] && sck_sync_q[2];
    assign cs_rise  = cs_hi && !cs_prev_q;

    // ------------------------------------------------------------
    // Storage and protection decode
    // ------------------------------------------------------------
    logic [7:0] mem [ARRAY_DEPTH];
    logic [7:0] page_buf [PAGE_BYTES];

    function automatic logic guarded(input logic [1:0] code, input logic [ARRAY_AW-1:0] a);
        unique case (code)
            2'h0: guarded = 1'b0;
            2'h1: guarded = a[ARRAY_AW-1 -: 2] == 2'h3;
            2'h2: guarded = a[ARRAY_AW-1];
            2'h3: guarded = 1'b1;
        endcase
    endfunction : guarded

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    phase_e                phase_q;
    logic [2:0]            bit_cnt_q;
    logic [6:0]            sh_q;
    logic [7:0]            addr_hi_q;
    logic [ARRAY_AW-1:0]   addr_q;
    logic [7:0]            out_sr_q;
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0]            sr_new_q;
    logic                  wr_ok_q;
    logic                  latch_set_cmd_pend_q;
    logic                  kind_sr_q;
    logic                  wel_q;
    logic                  busy_q;
    logic [1:0]            guard_q;
    logic                  prot_en_q;
    logic [23:0]           timer_q;
    logic [COMMIT_AW-1:0]  commit_q;
    logic                  latch_clear_cmd_hit;

    logic [7:0] rx_byte;
    logic       byte_done;
    logic [7:0] status;
    logic [ARRAY_AW-1:0] addr_in;
    assign rx_byte   = {sh_q, si_s};
    assign byte_done = sck_rise && bit_cnt_q == 3'h7;
    assign addr_in   = {addr_hi_q[ARRAY_AW-9:0], rx_byte};
    assign status    = {prot_en_q, SR_FIXED, guard_q, wel_q, busy_q};
    assign latch_clear_cmd_hit  = byte_done && phase_q == ST_OPCODE && !busy_q && rx_byte == OP_LATCH_CLR;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_cnt_q <= 3'h0;
            sh_q      <= 7'h0;
        end else if (cs_hi) begin
            bit_cnt_q <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            sh_q      <= rx_byte[6:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_q     <= ST_OPCODE;
            addr_hi_q   <= 8'h0;
            addr_q      <= '0;
            out_sr_q    <= 8'h0;
            mask_q      <= '0;
            sr_new_q    <= 8'h0;
            wr_ok_q     <= 1'b0;
            latch_set_cmd_pend_q <= 1'b0;
            kind_sr_q   <= 1'b0;
        end else if (cs_hi) begin
            // A new command is only decoded after select falls again
            phase_q     <= ST_OPCODE;
            latch_set_cmd_pend_q <= 1'b0;
            wr_ok_q     <= 1'b0;
        end else if (sck_fall && (phase_q == ST_RD_DATA || phase_q == ST_SR_OUT)) begin
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end else if (sck_rise) begin
            wr_ok_q <= 1'b0;
            if (bit_cnt_q == 3'h7) begin
                unique case (phase_q)
                    ST_OPCODE: begin
                        phase_q <= ST_IGNORE;
                        if (busy_q && rx_byte != OP_STATUS_FETCH) begin
                            phase_q <= ST_IGNORE;
                        end else if (rx_byte == OP_LATCH_SET) begin
                            latch_set_cmd_pend_q <= 1'b1;
                        end else if (rx_byte == OP_STATUS_FETCH) begin
                            out_sr_q <= status;
                            phase_q  <= ST_SR_OUT;
                        end else if (rx_byte == OP_STATUS_STORE) begin
                            phase_q  <= ST_SR_DATA;
                        end else if (rx_byte == OP_ARRAY_READ) begin
                            kind_sr_q <= 1'b0;
                            phase_q   <= ST_ADDR_HI;
                        end else if (rx_byte == OP_ARRAY_WRITE) begin
                            kind_sr_q <= 1'b1;
                            phase_q   <= ST_ADDR_HI;
                        end
                    end
                    ST_ADDR_HI: begin
                        addr_hi_q <= rx_byte;
                        phase_q   <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        if (!kind_sr_q) begin
                            out_sr_q <= mem[addr_in];
                            addr_q   <= addr_in + 1'b1;
                            phase_q  <= ST_RD_DATA;
                        end else begin
                            addr_q  <= addr_in;
                            mask_q  <= '0;
                            kind_sr_q <= 1'b0;
                            phase_q <= ST_WR_DATA;
                        end
                    end
                    ST_RD_DATA: begin
                        // Pointer width matches the array, so it wraps to zero
                        out_sr_q <= mem[addr_q];
                        addr_q   <= addr_q + 1'b1;
                    end
                    ST_WR_DATA: begin
                        mask_q[addr_q[PAGE_AW-1:0]]   <= 1'b1;
                        addr_q[PAGE_AW-1:0] <= addr_q[PAGE_AW-1:0] + 1'b1;
                        wr_ok_q <= 1'b1;
                    end
                    ST_SR_DATA: begin
                        sr_new_q <= rx_byte;
                        wr_ok_q  <= 1'b1;
                        kind_sr_q <= 1'b1;
                        phase_q  <= ST_IGNORE;
                    end
                    ST_SR_OUT: out_sr_q <= status;
                    ST_IGNORE: phase_q <= ST_IGNORE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Output pin: driven only inside a read phase with select low
    // ------------------------------------------------------------
    logic so_q;
    logic so_oe_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            so_q    <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (cs_hi) begin
            so_oe_q <= 1'b0;
        end else if (sck_fall && (phase_q == ST_RD_DATA || phase_q == ST_SR_OUT)) begin
            so_q    <= out_sr_q[7];
            so_oe_q <= 1'b1;
        end
    end

    assign o_so    = so_q;
    assign o_so_oe = so_oe_q;
    assign o_busy  = busy_q;

    // ------------------------------------------------------------
    // Latch, status bits and self-timed write cycle
    // ------------------------------------------------------------
    logic start_wr;
    logic commit_en;
    logic [ARRAY_AW-1:0] commit_addr;
    assign start_wr    = cs_rise && wr_ok_q && wel_q && !busy_q;
    assign commit_en   = busy_q && !kind_sr_q && commit_q < COMMIT_AW'(PAGE_BYTES);
    assign commit_addr = {addr_q[ARRAY_AW-1:PAGE_AW], commit_q[PAGE_AW-1:0]};

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q   <= 1'b0;
            timer_q  <= 24'h0;
            commit_q <= '0;
        end else if (start_wr) begin
            busy_q   <= 1'b1;
            timer_q  <= 24'(P_WRITE_CYCLES - 1);
            commit_q <= '0;
        end else if (busy_q) begin
            if (timer_q == 24'h0) begin
                busy_q <= 1'b0;
            end else begin
                timer_q <= timer_q - 24'h1;
            end
            if (commit_en) begin
                commit_q <= commit_q + 1'b1;
            end
        end
    end

    // Bytes are committed one per cycle early in the cycle; guarded bytes are dropped
    always_ff @(posedge i_core_clk) begin
        if (commit_en && mask_q[commit_q[PAGE_AW-1:0]] && !guarded(guard_q, commit_addr)) begin
            mem[commit_addr] <= page_buf[commit_q[PAGE_AW-1:0]];
        end
        if (byte_done && phase_q == ST_WR_DATA) begin
            page_buf[addr_q[PAGE_AW-1:0]] <= rx_byte;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wel_q     <= 1'b0;
            guard_q   <= GUARD_RST;
            prot_en_q <= PROT_EN_RST;
        end else if (busy_q && timer_q == 24'h0) begin
            wel_q <= 1'b0;
            if (kind_sr_q) begin
                prot_en_q <= sr_new_q[SR_PROT_EN_BIT];
                guard_q   <= sr_new_q[SR_GUARD_HI:SR_GUARD_LO];
            end
        end else if (latch_clear_cmd_hit) begin
            wel_q <= 1'b0;
        end else if (cs_rise && latch_set_cmd_pend_q) begin
            wel_q <= 1'b1;
        end
    end

    // Status store reuses kind flag: set when a status byte arrives
    logic unused_ok;
    assign unused_ok = sr_new_q[SR_BUSY_BIT] ^ sr_new_q[SR_WEL_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_so_hiz;
        @(posedge i_core_clk) disable iff (!i_nrst)
        cs_hi |=> !o_so_oe;
    endproperty
    a_so_hiz: assert property (p_so_hiz) else $error("output driven while deselected");

    property p_so_on_fall;
        @(posedge i_core_clk) disable iff (!i_nrst)
        $changed(o_so) |-> $past(sck_fall);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off falling edge");

    property p_bits_on_rise;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (bit_cnt_q != $past(bit_cnt_q)) |-> $past(sck_rise) || $past(cs_hi);
    endproperty
    a_bits_on_rise: assert property (p_bits_on_rise) else $error("bit taken off rising edge");

    property p_busy_start;
        @(posedge i_core_clk) disable iff (!i_nrst)
        $rose(busy_q) |-> $past(cs_rise) && $past(wel_q) && $past(wr_ok_q);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("write began without select rise");

    property p_wel_set;
        @(posedge i_core_clk) disable iff (!i_nrst)
        $rose(wel_q) |-> $past(cs_rise) && $past(latch_set_cmd_pend_q);
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch set without select rise");

    property p_wel_end;
        @(posedge i_core_clk) disable iff (!i_nrst)
        $fell(busy_q) |-> !wel_q;
    endproperty
    a_wel_end: assert property (p_wel_end) else $error("latch survived write end");

    property p_busy_ignore;
        @(posedge i_core_clk) disable iff (!i_nrst)
        byte_done && phase_q == ST_OPCODE && busy_q && rx_byte != OP_STATUS_FETCH
            |=> phase_q == ST_IGNORE;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

    property p_status_out;
        @(posedge i_core_clk) disable iff (!i_nrst)
        byte_done && phase_q == ST_OPCODE && rx_byte == OP_STATUS_FETCH
            |=> phase_q == ST_SR_OUT && out_sr_q == $past(status);
    endproperty
    a_status_out: assert property (p_status_out) else $error("status fetch not loaded");

    property p_timer_bound;
        @(posedge i_core_clk) disable iff (!i_nrst)
        busy_q |-> timer_q < 24'(P_WRITE_CYCLES);
    endproperty
    a_timer_bound: assert property (p_timer_bound) else $error("write cycle too long");

    property p_fixed_bits;
        @(posedge i_core_clk) disable iff (!i_nrst)
        status[6:4] == SR_FIXED && status[SR_BUSY_BIT] == busy_q;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("status layout broken");

    c_read: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        phase_q == ST_RD_DATA && byte_done);
    c_write: cover property (@(posedge i_core_clk) disable iff (!i_nrst) $rose(busy_q));
    c_poll: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
        busy_q && phase_q == ST_SR_OUT);

endmodule : spi_nvm_access

// ==== spi_host_model.sv ====
module spi_host_model (
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime    half = 62.5ns;
    logic       cpol = 1'b0;
    logic       oe_seen = 1'b0;
    logic       rx_ok = 1'b0;
    logic [7:0] rx = 8'h00;
    event       rx_done;
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end
    // ------------------------------------------------------------
    // Frame control
    // ------------------------------------------------------------
    // Clock is parked at the idle level of the chosen mode before select drops
    task sel();
        o_sck   = cpol;
        #(half);
        o_cs_n  = 1'b0;
        oe_seen = 1'b0;
        #(half);
    endtask : sel
    // Data changes on the fall, device samples on the rise; SO read at the rise
    // Flags change only at a rise, so the byte checker reads settled values
    task xb(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            o_sck   = 1'b0;
            o_si    = tx[i];
            #(half);
            o_sck   = 1'b1;
            rx[i]   = i_so;
            rx_ok   = (i == 7) ? i_so_oe : (rx_ok & i_so_oe);
            oe_seen = oe_seen | i_so_oe;
            #(half);
        end
        ->rx_done;
    endtask : xb
    // Raising select ends the frame; released SI shows a changed level
    task desel();
        o_sck  = cpol;
        #(half);
        o_cs_n = 1'b1;
        o_si   = ~o_si;
        #(4 * half);
    endtask : desel
endmodule : spi_host_model

// ==== spi_eeprom_command_access_tb.sv ====
module spi_eeprom_command_access_tb;
    import spi_nvm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P_WR = 1000;
    logic        i_core_clk;
    logic        i_nrst;
    logic        cs_n, sck, si, so, so_oe, busy;
    logic [7:0]  mem [0:2047];
    logic [7:0]  exp_q [$];
    logic [1:0]  guard;
    logic        pe, busy_seen;
    logic [10:0] pre [6] = '{11'h000, 11'h3ff, 11'h400, 11'h5ff, 11'h600, 11'h7ff};
    logic [10:0] bnd [4] = '{11'h000, 11'h600, 11'h400, 11'h000};
    logic [7:0]  d;
    int          num_errors, tests_run, seed, bcnt;

    spi_nvm_access #(.P_WRITE_CYCLES(P_WR)) spi_nvm_access_i (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sck(sck),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_busy(busy));
    spi_host_model spi_host_model_i (
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // ------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task tend(input string nm);
        $display("test %s done, mismatches so far %0d", nm, num_errors);
    endtask : tend
    task test_done();
        check("notes left", 16'h0, 16'(exp_q.size()));
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // Every byte the device actually drives is matched against the oldest note
    always @(spi_host_model_i.rx_done) begin
        if (spi_host_model_i.rx_ok === 1'b1) begin
            check("so byte", exp_q.size() ? exp_q.pop_front() : 8'hxx, spi_host_model_i.rx);
        end
    end
    always @(posedge i_core_clk) begin
        if (busy === 1'b1) begin
            bcnt <= bcnt + 1;
            busy_seen <= 1'b1;
        end else if (bcnt != 0) begin
            check("busy cycles", 16'(P_WR), 16'(bcnt));
            bcnt <= 0;
        end
    end
    initial begin
        #600us;
        num_errors++;
        $display("watchdog expired");
        test_done();
    end
    // ------------------------------------------------------------
    // Serial commands
    // ------------------------------------------------------------
    function automatic logic [7:0] sr(input logic wl, input logic bz);
        return {pe, SR_FIXED, guard, wl, bz};
    endfunction : sr
    function automatic logic prot(input logic [10:0] a);
        case (guard)
            2'h1: return a >= 11'h600;
            2'h2: return a >= 11'h400;
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : prot
    task start(input logic [7:0] op);
        @(posedge i_core_clk);
        #2;
        spi_host_model_i.cpol = 1'($random(seed));
        spi_host_model_i.sel();
        spi_host_model_i.xb(op);
    endtask : start
    // Upper five address bits are random: they must be ignored
    task addr(input logic [10:0] a);
        d = 8'($random(seed));
        spi_host_model_i.xb({d[4:0], a[10:8]});
        spi_host_model_i.xb(a[7:0]);
    endtask : addr
    task op8(input logic [7:0] op);
        start(op);
        spi_host_model_i.desel();
    endtask : op8
    task stat(input logic [7:0] e);
        start(OP_STATUS_FETCH);
        repeat (2) begin
            exp_q.push_back(e);
            spi_host_model_i.xb(8'($random(seed)));
        end
        spi_host_model_i.desel();
    endtask : stat
    task rd(input logic [10:0] a, input int n);
        start(OP_ARRAY_READ);
        addr(a);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[11'(a + i)]);
            spi_host_model_i.xb(8'($random(seed)));
        end
        spi_host_model_i.desel();
    endtask : rd
    // Mode 1 expects a write cycle, mode 2 checks nothing and only waits out one if it starts
    task wt(input int m);
        for (int k = 0; k < 1500 && !(busy_seen && busy === 1'b0)
             && !(m == 2 && k > 60 && !busy_seen); k++) @(posedge i_core_clk);
        if (m == 1) check("write started", 16'h1, 16'(busy_seen));
        busy_seen = 1'b0;
    endtask : wt
    task wr(input logic [10:0] a, input int n, input int m);
        logic [10:0] ea;
        op8(OP_LATCH_SET);
        start(OP_ARRAY_WRITE);
        addr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            ea = {a[10:5], 5'(a[4:0] + i)};
            if (!prot(ea)) mem[ea] = d;
            spi_host_model_i.xb(d);
        end
        spi_host_model_i.desel();
        if (m != 0) wt(m);
    endtask : wr
    task ws(input logic [7:0] v);
        op8(OP_LATCH_SET);
        start(OP_STATUS_STORE);
        spi_host_model_i.xb(v);
        spi_host_model_i.desel();
        wt(1);
        guard = v[3:2];
        pe = v[7];
    endtask : ws
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h8449;
        i_nrst = 1'b0;
        {guard, pe, busy_seen, bcnt, num_errors, tests_run} = '0;
        repeat (4) @(posedge i_core_clk);
        #2 i_nrst = 1'b1;
        repeat (3) @(posedge i_core_clk);
        check("oe idle", 16'h0, 16'(so_oe));
        stat(sr(1'b0, 1'b0));
        op8(OP_LATCH_SET);
        stat(sr(1'b1, 1'b0));
        op8(OP_LATCH_CLR);
        stat(sr(1'b0, 1'b0));
        start(8'h5a);
        addr(11'h0);
        spi_host_model_i.desel();
        check("oe bad opcode", 16'h0, 16'(spi_host_model_i.oe_seen));
        start(OP_LATCH_SET);
        spi_host_model_i.xb(OP_ARRAY_WRITE);
        addr(11'h0);
        spi_host_model_i.xb(8'h11);
        spi_host_model_i.desel();
        repeat (40) @(posedge i_core_clk);
        check("write without cs rise", 16'h0, 16'(busy_seen));
        tend("latch");
        foreach (pre[i]) wr(pre[i], 1, 1);
        wr(11'h7fe, 3, 0);
        start(OP_ARRAY_READ);
        addr(11'h0);
        spi_host_model_i.desel();
        check("oe read while busy", 16'h0, 16'(spi_host_model_i.oe_seen));
        stat(sr(1'b1, 1'b1));
        wt(1);
        stat(sr(1'b0, 1'b0));
        rd(11'h7fe, 3);
        rd(11'h7e0, 1);
        tend("array");
        spi_host_model_i.half = 100ns;
        for (int g = 1; g < 4; g++) begin
            d = 8'($random(seed));
            ws({d[7:4], 2'(g), d[1:0]});
            stat(sr(1'b0, 1'b0));
            wr(bnd[g] - 11'h1, 1, (g == 3) ? 2 : 1);
            wr(bnd[g], 1, 2);
            rd(bnd[g] - 11'h1, 2);
        end
        tend("guard");
        test_done();
    end
endmodule : spi_eeprom_command_access_tb
